// ---- lvmc_pkg.sv ----
// Purpose: Constants for the low-voltage monitor control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Status/clear/enable registers form the interrupt group
`default_nettype none
package lvmc_pkg;
    localparam logic [11:0] ADDR_SMSC = 12'h000;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h008;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00C;
    localparam int BIT_WARN_FLAG = 7;
    localparam int BIT_WARN_ACK = 6;
    localparam int BIT_WARN_IRQ_EN = 5;
    localparam int BIT_RESET_EN = 4;
    localparam int BIT_STOP_EN = 3;
    localparam int BIT_DETECT_EN = 2;
    localparam int BIT_REF_BUF_EN = 0;
    localparam logic [7:0] SMSC_RESET = 8'h1C;
    localparam logic [7:0] SMSC_WRITABLE = 8'h3D;
    localparam int EVT_WARN = 0;
    localparam int EVT_DETECT = 1;
    localparam int EVT_WIDTH = 2;
    localparam logic [1:0] EVT_RESET = 2'h0;
endpackage
`default_nettype wire

// ---- lvmc_sticky.sv ----
// Purpose: One sticky flag, set wins over clear
// Assumes: Synchronous active-high reset
// Notes: Used for warning flag and interrupt status bits
`default_nettype none
module lvmc_sticky (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_r;
    logic flag_nxt;

    always_comb
    begin
        flag_nxt = flag_r;
        if (clr_i)
            flag_nxt = 1'b0;
        if (set_i)
            flag_nxt = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

    assign flag_o = flag_r;
endmodule
`default_nettype wire

// ---- lvmc_once.sv ----
// Purpose: Write-once control bit
// Assumes: Synchronous active-high reset
// Notes: First write after reset is taken, later ones are ignored
`default_nettype none
module lvmc_once (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reset_val_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic bit_o
);
    logic bit_r;
    logic bit_nxt;
    logic used_r;
    logic used_nxt;

    always_comb
    begin
        bit_nxt = bit_r;
        used_nxt = used_r;
        if (wr_i && !used_r)
        begin
            bit_nxt = wdata_i;
            used_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            bit_r <= 1'b0;
            used_r <= 1'b0;
        end
        else
        begin
            bit_r <= bit_nxt;
            used_r <= used_nxt;
        end
    end

    assign bit_o = used_r ? bit_r : reset_val_i;
endmodule
`default_nettype wire

// ---- lvmc_top.sv ----
// Purpose: Supply monitor status and control register with APB access
// Assumes: Monitor inputs synchronous to clk; stop_mode from power control
// Notes: Zero-wait APB slave; unmapped addresses read 0 with pslverr
//
// The APB interface to the registers and the register addresses were left to the implementer.
`default_nettype none
// Behaviour
// - Warning flag bit 7 sets on low supply, including already low after reset.
// - Warning flag is sticky until cleared.
// - Writing 1 to ack bit 6 clears flag only if warning gone.
// - Interrupt request while flag set and warning interrupt enable bit 5 set.
// - Reset enable bit 4 with detection on makes detect events force reset.
// - Detect and reset enable bits take only first write after reset.
// - Stop enable bit 3 keeps detection active in stop mode.
// - Detect enable bit 2 turns detection on and gates bits 4 and 3.
// - Reference buffer enable bit 0 drives buffer enable output.
// - Register is 8 bits, reset value 1Ch.
module lvmc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic low_supply_warning,
    input wire logic undervoltage_detect,
    input wire logic stop_mode,
    output logic undervoltage_detect_active,
    output logic undervoltage_reset_req,
    output logic reference_buffer_en,
    output logic warn_irq,
    output logic irq
);
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic acc;
    logic wr;
    logic wr_smsc;
    logic wr_clr;
    logic wr_en;
    logic mapped;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign wr_smsc = wr && (paddr == lvmc_pkg::ADDR_SMSC);
    assign wr_clr = wr && (paddr == lvmc_pkg::ADDR_IRQ_CLEAR);
    assign wr_en = wr && (paddr == lvmc_pkg::ADDR_IRQ_ENABLE);
    assign mapped = (paddr == lvmc_pkg::ADDR_SMSC) || (paddr == lvmc_pkg::ADDR_IRQ_STATUS)
        || (paddr == lvmc_pkg::ADDR_IRQ_CLEAR) || (paddr == lvmc_pkg::ADDR_IRQ_ENABLE);

    // ----------------------------------------------------------------
    // Control bits
    // ----------------------------------------------------------------
    logic irq_en_r;
    logic irq_en_nxt;
    logic stop_en_r;
    logic stop_en_nxt;
    logic refbuf_r;
    logic refbuf_nxt;
    logic [1:0] evt_en_r;
    logic [1:0] evt_en_nxt;
    logic detect_en;
    logic reset_en;

    always_comb
    begin
        irq_en_nxt = irq_en_r;
        stop_en_nxt = stop_en_r;
        refbuf_nxt = refbuf_r;
        evt_en_nxt = evt_en_r;
        if (wr_smsc)
        begin
            irq_en_nxt = pwdata[lvmc_pkg::BIT_WARN_IRQ_EN];
            stop_en_nxt = pwdata[lvmc_pkg::BIT_STOP_EN];
            refbuf_nxt = pwdata[lvmc_pkg::BIT_REF_BUF_EN];
        end
        if (wr_en)
            evt_en_nxt = pwdata[1:0];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            irq_en_r <= lvmc_pkg::SMSC_RESET[lvmc_pkg::BIT_WARN_IRQ_EN];
            stop_en_r <= lvmc_pkg::SMSC_RESET[lvmc_pkg::BIT_STOP_EN];
            refbuf_r <= lvmc_pkg::SMSC_RESET[lvmc_pkg::BIT_REF_BUF_EN];
            evt_en_r <= lvmc_pkg::EVT_RESET;
        end
        else
        begin
            irq_en_r <= irq_en_nxt;
            stop_en_r <= stop_en_nxt;
            refbuf_r <= refbuf_nxt;
            evt_en_r <= evt_en_nxt;
        end
    end

    lvmc_once u_detect_en (
        .clk(clk),
        .sys_rst(sys_rst),
        .reset_val_i(lvmc_pkg::SMSC_RESET[lvmc_pkg::BIT_DETECT_EN]),
        .wr_i(wr_smsc),
        .wdata_i(pwdata[lvmc_pkg::BIT_DETECT_EN]),
        .bit_o(detect_en)
    );

    lvmc_once u_reset_en (
        .clk(clk),
        .sys_rst(sys_rst),
        .reset_val_i(lvmc_pkg::SMSC_RESET[lvmc_pkg::BIT_RESET_EN]),
        .wr_i(wr_smsc),
        .wdata_i(pwdata[lvmc_pkg::BIT_RESET_EN]),
        .bit_o(reset_en)
    );

    // ----------------------------------------------------------------
    // Warning flag
    // ----------------------------------------------------------------
    logic warn_flag;
    logic warn_clr;

    assign warn_clr = wr_smsc && pwdata[lvmc_pkg::BIT_WARN_ACK] && !low_supply_warning;

    lvmc_sticky u_warn (
        .clk(clk),
        .sys_rst(sys_rst),
        .set_i(low_supply_warning),
        .clr_i(warn_clr),
        .flag_o(warn_flag)
    );

    // ----------------------------------------------------------------
    // Detection gating and interrupt status
    // ----------------------------------------------------------------
    logic det_active;
    logic det_event;
    logic [1:0] evt_set;
    logic [1:0] evt_sts;

    assign det_active = detect_en && (!stop_mode || stop_en_r);
    assign det_event = det_active && undervoltage_detect;
    assign evt_set[lvmc_pkg::EVT_WARN] = low_supply_warning && !warn_flag;
    assign evt_set[lvmc_pkg::EVT_DETECT] = det_event;

    genvar gi;
    generate
        for (gi = 0; gi < lvmc_pkg::EVT_WIDTH; gi++)
        begin : g_evt
            lvmc_sticky u_evt (
                .clk(clk),
                .sys_rst(sys_rst),
                .set_i(evt_set[gi]),
                .clr_i(wr_clr && pwdata[gi]),
                .flag_o(evt_sts[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic [7:0] smsc_rd;
    logic [31:0] rdata_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic active_r;
    logic rst_req_r;
    logic warn_irq_r;
    logic irq_r;

    always_comb
    begin
        smsc_rd = 8'h00;
        smsc_rd[lvmc_pkg::BIT_WARN_FLAG] = warn_flag;
        smsc_rd[lvmc_pkg::BIT_WARN_IRQ_EN] = irq_en_r;
        smsc_rd[lvmc_pkg::BIT_RESET_EN] = reset_en;
        smsc_rd[lvmc_pkg::BIT_STOP_EN] = stop_en_r;
        smsc_rd[lvmc_pkg::BIT_DETECT_EN] = detect_en;
        smsc_rd[lvmc_pkg::BIT_REF_BUF_EN] = refbuf_r;
        rdata_nxt = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                lvmc_pkg::ADDR_SMSC: rdata_nxt = {24'h00_0000, smsc_rd};
                lvmc_pkg::ADDR_IRQ_STATUS: rdata_nxt = {30'h0000_0000, evt_sts};
                lvmc_pkg::ADDR_IRQ_ENABLE: rdata_nxt = {30'h0000_0000, evt_en_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            active_r <= 1'b0;
            rst_req_r <= 1'b0;
            warn_irq_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            prdata_r <= rdata_nxt;
            pslverr_r <= psel && !penable && !mapped;
            active_r <= det_active;
            rst_req_r <= det_event && reset_en;
            warn_irq_r <= warn_flag && irq_en_r;
            irq_r <= |(evt_sts & evt_en_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = pslverr_r;
    assign undervoltage_detect_active = active_r;
    assign undervoltage_reset_req = rst_req_r;
    assign reference_buffer_en = refbuf_r;
    assign warn_irq = warn_irq_r;
    assign irq = irq_r;
endmodule
`default_nettype wire

// ---- lvmc_assertions.sv ----
// Purpose: Port checker for lvmc_top
// Assumes: Zero-wait APB, one clock
// Notes: Bound to every lvmc_top
`default_nettype none
module lvmc_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic low_supply_warning,
    input wire logic undervoltage_detect,
    input wire logic undervoltage_detect_active,
    input wire logic undervoltage_reset_req,
    input wire logic reference_buffer_en,
    input wire logic warn_irq
);
    // ------------
    // Properties
    // ------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence rd0;
        psel && !penable && !pwrite && paddr == 12'h000;
    endsequence
    sequence wr0;
        psel && penable && pwrite && paddr == 12'h000;
    endsequence
    ready_high_a: assert property (pready) else $error("pready low");
    flag_read_a: assert property (low_supply_warning ##1 rd0 |=> prdata[7])
        else $error("flag not read as set");
    zero_bits_a: assert property (rd0 |=> (prdata & 32'hFFFFFF42) == 32'h0)
        else $error("reserved bits not zero");
    unmapped_a: assert property (psel && !penable && paddr[11:4] != 8'h0 |=> pslverr)
        else $error("no error on unmapped");
    idle_data_a: assert property (!(psel && penable) |-> prdata == 32'h0)
        else $error("prdata outside access");
    ack_hold_a: assert property (wr0 ##0 pwdata[6] && pwdata[5] && low_supply_warning
        |=> ##1 warn_irq) else $error("ack cleared live warning");
    irq_off_a: assert property (wr0 ##0 !pwdata[5] |=> ##1 !warn_irq)
        else $error("irq with enable off");
    ref_buf_a: assert property (wr0 |=> ##1 reference_buffer_en == $past(pwdata[0], 2))
        else $error("buffer enable mismatch");
    reset_cause_a: assert property (undervoltage_reset_req |-> $past(undervoltage_detect))
        else $error("reset request without detect");
    active_rst_a: assert property ($fell(sys_rst) |-> !undervoltage_detect_active)
        else $error("detect active at reset");
endmodule
bind lvmc_top lvmc_chk u_chk (.*);
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for lvmc_top
// Assumes: Zero-wait APB slave
// Notes: Bus answers taken at the rising edge, pin outputs at the falling edge after pins, otherwise at the rising edge
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic low_supply_warning = 0, undervoltage_detect = 0, stop_mode = 0, irq, warn_irq;
    logic undervoltage_detect_active, undervoltage_reset_req, reference_buffer_en;
    int failures = 0, n_tests = 0;
    always #4 clk = ~clk;
    lvmc_top uut (.*);
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic pins(input logic w, input logic u, input logic s, input int n);
        @(posedge clk);
        low_supply_warning <= w;
        undervoltage_detect <= u;
        stop_mode <= s;
        repeat (n) @(negedge clk);
    endtask
    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        do_reset();
        rdc("ctrl", 12'h000, 32'h1C);
        rdc("irq_en", 12'h00C, 32'h0);
        rdc("unmapped", 12'h010, 32'h0);
        chk1("slverr", 1'h1, er);
        chk1("refbuf", 1'h0, reference_buffer_en);
        apb(1'h1, 12'h000, 32'h1C);
        rdc("init_wr", 12'h000, 32'h1C);
        $display("reset test done");
    endtask
    task automatic t_warn();
        pins(1'h1, 1'h0, 1'h0, 1);
        do_reset();
        rdc("flag_rst", 12'h000, 32'h9C);
        apb(1'h1, 12'h000, 32'h7C);
        rdc("flag_kept", 12'h000, 32'hBC);
        pins(1'h0, 1'h0, 1'h0, 2);
        rdc("flag_sticky", 12'h000, 32'hBC);
        apb(1'h1, 12'h000, 32'h5C);
        rdc("flag_clr", 12'h000, 32'h1C);
        apb(1'h1, 12'h00C, 32'h1);
        apb(1'h1, 12'h000, 32'h3C);
        chk1("wirq_idle", 1'h0, warn_irq);
        pins(1'h1, 1'h0, 1'h0, 3);
        chk1("wirq_set", 1'h1, warn_irq);
        chk1("irq_set", 1'h1, irq);
        rdc("status", 12'h004, 32'h1);
        pins(1'h0, 1'h0, 1'h0, 1);
        apb(1'h1, 12'h000, 32'h1C);
        apb(1'h1, 12'h00C, 32'h0);
        pins(1'h0, 1'h0, 1'h0, 2);
        chk1("wirq_off", 1'h0, warn_irq);
        chk1("irq_mask", 1'h0, irq);
        apb(1'h1, 12'h008, 32'h3);
        rdc("status_clr", 12'h004, 32'h0);
        $display("warning test done");
    endtask
    task automatic t_once();
        do_reset();
        apb(1'h1, 12'h000, 32'h11);
        rdc("first_wr", 12'h000, 32'h11);
        chk1("refbuf_on", 1'h1, reference_buffer_en);
        apb(1'h1, 12'h000, 32'h1E);
        rdc("locked", 12'h000, 32'h18);
        pins(1'h0, 1'h1, 1'h0, 3);
        chk1("no_detect", 1'h0, undervoltage_detect_active);
        chk1("no_reset", 1'h0, undervoltage_reset_req);
        $display("write once test done");
    endtask
    task automatic t_det();
        pins(1'h0, 1'h0, 1'h0, 1);
        do_reset();
        apb(1'h1, 12'h000, 32'h14);
        pins(1'h0, 1'h1, 1'h0, 3);
        chk1("reset_req", 1'h1, undervoltage_reset_req);
        pins(1'h0, 1'h1, 1'h1, 3);
        chk1("stop_off", 1'h0, undervoltage_detect_active);
        apb(1'h1, 12'h000, 32'h1C);
        pins(1'h0, 1'h1, 1'h1, 3);
        chk1("stop_on", 1'h1, undervoltage_detect_active);
        rdc("status_det", 12'h004, 32'h2);
        pins(1'h0, 1'h0, 1'h0, 1);
        $display("detect test done");
    endtask
    initial
    begin
        t_reset();
        t_warn();
        t_once();
        t_det();
        report_and_stop();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
